// [hdl/sfs_defs.vh]
// Constants for the serial flash status-write and read logic.
// Assumes inclusion by bare name from design and bench files.
`ifndef SFS_DEFS_VH
`define SFS_DEFS_VH
// Opcodes
`define SFS_OP_WR_EN 8'h06
`define SFS_OP_WR_STAT 8'h01
`define SFS_OP_RDSR 8'h05
`define SFS_OP_RDCR 8'h15
`define SFS_OP_READ 8'h03
`define SFS_OP_FAST 8'h0b
`define SFS_OP_PROG 8'h02
`define SFS_OP_ERASE 8'h20
// Status register bit positions
`define SFS_SR_BUSY 0
`define SFS_SR_LATCH 1
`define SFS_SR_BP_LO 2
`define SFS_SR_BP_HI 5
`define SFS_SR_QUAD 6
`define SFS_SR_WDIS 7
// Configuration register bit positions
`define SFS_CR_TB 3
`define SFS_CR_DUM_LO 6
`define SFS_CR_DUM_HI 7
// Reset values
`define SFS_SR_RST 8'h00
`define SFS_CR_RST 8'h07
// Dummy counts per dummy field value
`define SFS_DUM_00 4'h8
`define SFS_DUM_01 4'h6
`define SFS_DUM_10 4'h8
`define SFS_DUM_11 4'ha
// Timing
`define SFS_CLK_MHZ 40
`define SFS_STAT_US 40
`define SFS_STAT_CYC (`SFS_STAT_US * `SFS_CLK_MHZ)
`endif

// [hdl/sfs_mem.v]
// Small synchronous array memory with registered read data.
// Assumes a single clock; writes are single byte.
`timescale 1ns/1ps
`default_nettype none
module sfs_mem #(
   parameter AW = 10
) (
   // Clock
   input wire clk,
   // Write port
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [7:0] wdata,
   // Read port
   input wire [AW-1:0] raddr,
   output reg [7:0] rdata
);
   reg [7:0] mem [0:(1<<AW)-1];
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // sfs_mem
`default_nettype wire

// [hdl/sfs_top.v]
// Serial flash command logic: status/config write, protection, reads.
// Assumes the host drives cs_n, sclk and si asynchronously to clk;
// sclk must be well below clk/4 so every edge is seen.
`timescale 1ns/1ps
`default_nettype none
`include "sfs_defs.vh"
// Notes on behaviour
// - Dummy count from two-bit field: fast read 8,6,8,10.
// - Status write executes only when write latch already set.
// - Status write changes protect, quad and disable bits, keeps bit 1, sets bit 0.
// - Select must rise after exactly 8 or 16 data bits, else no effect.
// - Self-timed cycle starts at select rise (erase: at last address bit); status reads still served.
// - Busy flag high for whole cycle, then busy and latch cleared.
// - Opcode taken as 8 clocks single-line; upper lines ignored.
// - Write allowed if disable bit 0, or disable bit 1 and pin high.
// - Disable bit 1 with pin low rejects status writes unless quad or four-line mode.
// - Hardware protection when disable bit 1 and pin low, with quad and four-line off.
// - Hardware protection off in four-line mode or quad enable set.
// - Program and erase blocked in area chosen by protect bits.
// - Normal read: opcode, 3-byte address, data on falling edges.
// - Address advances per byte and wraps to zero at top.
// - Select rise during data out stops driving and aborts.
// - Normal and fast reads rejected while a write cycle is in progress.
// - Fast read: opcode, address, configured dummy clocks, then data.
// - Dummy field sits in configuration bits 7 and 6.
// - Write enable sets latch; program/erase need it, clear it at end.
// - Quad enable 0 keeps shared pin as write protect.
module sfs_top #(
   parameter AW = 10,
   parameter STAT_CYC = `SFS_STAT_CYC,
   parameter PE_CYC = 64
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Serial link pins
   input wire cs_n,
   input wire sclk,
   input wire si,
   input wire write_protect_n_pin,
   output reg so,
   output wire so_oe_n,
   // Mode and state
   input wire four_line_command_mode,
   output wire [7:0] status_reg,
   output wire [7:0] config_reg,
   output wire hardware_protect_mode,
   output wire software_protect_mode
);
   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   reg [1:0] cs_s_r;
   reg [1:0] ck_s_r;
   reg [1:0] si_s_r;
   reg [1:0] wp_s_r;
   reg ck_d_r;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cs_s_r <= 2'b11;
         ck_s_r <= 2'b00;
         si_s_r <= 2'b00;
         wp_s_r <= 2'b11;
         ck_d_r <= 1'b0;
      end else begin
         cs_s_r <= {cs_s_r[0], cs_n};
         ck_s_r <= {ck_s_r[0], sclk};
         si_s_r <= {si_s_r[0], si};
         wp_s_r <= {wp_s_r[0], write_protect_n_pin};
         ck_d_r <= ck_s_r[1];
      end
   end
   wire cs_q = cs_s_r[1];
   wire wp_q = wp_s_r[1];
   wire si_q = si_s_r[1];
   wire rise = ck_s_r[1] & ~ck_d_r & ~cs_q;
   wire fall = ~ck_s_r[1] & ck_d_r & ~cs_q;
   reg cs_d_r;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cs_d_r <= 1'b1;
      end else begin
         cs_d_r <= cs_q;
      end
   end
   wire cs_rise = cs_q & ~cs_d_r;
   ////////////////////////////////////////////////////////////////////////
   // Registers and protection
   reg [7:0] sr_r;
   reg [7:0] cr_r;
   assign status_reg = sr_r;
   assign config_reg = cr_r;
   wire busy = sr_r[`SFS_SR_BUSY];
   wire write_latch = sr_r[`SFS_SR_LATCH];
   wire quad_enable = sr_r[`SFS_SR_QUAD];
   wire status_write_disable = sr_r[`SFS_SR_WDIS];
   wire [3:0] bp = sr_r[`SFS_SR_BP_HI:`SFS_SR_BP_LO];
   // Shared pin is protect only while quad is off
   wire hwp_off = four_line_command_mode | quad_enable;
   assign hardware_protect_mode = status_write_disable & ~wp_q
      & ~hwp_off;
   assign software_protect_mode = ~hardware_protect_mode;
   wire sr_write_ok = write_latch & ~hardware_protect_mode;
   reg [3:0] dummy_n;
   always @* begin
      case (cr_r[`SFS_CR_DUM_HI:`SFS_CR_DUM_LO])
         2'b00: dummy_n = `SFS_DUM_00;
         2'b01: dummy_n = `SFS_DUM_01;
         2'b10: dummy_n = `SFS_DUM_10;
         default: dummy_n = `SFS_DUM_11;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////
   // Command state machine
   localparam ST_OP = 6'b000001;
   localparam ST_ADR = 6'b000010;
   localparam ST_DUM = 6'b000100;
   localparam ST_DAT = 6'b001000;
   localparam ST_WR = 6'b010000;
   localparam ST_IGN = 6'b100000;
   reg [5:0] st_r;
   reg [7:0] op_r;
   reg [23:0] sh_r;
   reg [4:0] bit_r;
   reg [4:0] wbits_r;
   reg [15:0] wdat_r;
   reg [AW-1:0] addr_r;
   reg [3:0] dcnt_r;
   reg [7:0] obyte_r;
   reg [2:0] obit_r;
   reg drive_r;
   reg pe_wr_r;
   reg [7:0] pe_dat_r;
   wire [7:0] mem_q;
   wire [7:0] op_nxt = {sh_r[6:0], si_q};
   wire [23:0] adr_nxt = {sh_r[22:0], si_q};
   // Protected region: top (tb=0) or bottom area, size 2^bp blocks of 32
   wire [AW-1:0] pe_addr = adr_nxt[AW-1:0];
   wire [AW-1:0] span = (bp == 4'h0) ? {AW{1'b0}}
      : ({{(AW-1){1'b0}}, 1'b1} << (bp + 4'h5));
   wire in_prot = (bp != 4'h0) & ((bp >= 4'h5) | (cr_r[`SFS_CR_TB]
      ? (pe_addr < span) : (pe_addr >= ({AW{1'b1}} - span + 1'b1))));
   ////////////////////////////////////////////////////////////////////////
   // Self-timed cycle timer
   reg [31:0] tmr_r;
   reg pe_kind_r;
   wire tmr_done = busy & (tmr_r == 32'h1);
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= ST_OP;
         op_r <= 8'h00;
         sh_r <= 24'h000000;
         bit_r <= 5'h00;
         wbits_r <= 5'h00;
         wdat_r <= 16'h0000;
         addr_r <= {AW{1'b0}};
         dcnt_r <= 4'h0;
         obyte_r <= 8'h00;
         obit_r <= 3'h0;
         drive_r <= 1'b0;
         so <= 1'b0;
         pe_wr_r <= 1'b0;
         pe_dat_r <= 8'h00;
         sr_r <= `SFS_SR_RST;
         cr_r <= `SFS_CR_RST;
         tmr_r <= 32'h0;
         pe_kind_r <= 1'b0;
      end else begin
         pe_wr_r <= 1'b0;
         // Timer and completion
         if (tmr_done) begin
            sr_r[`SFS_SR_BUSY] <= 1'b0;
            sr_r[`SFS_SR_LATCH] <= 1'b0;
            if (pe_kind_r) begin
               pe_wr_r <= 1'b1;
            end
            tmr_r <= 32'h0;
         end else if (busy) begin
            tmr_r <= tmr_r - 32'h1;
         end
         if (cs_q) begin
            // Select high ends every transfer; a complete status write or program commits on its rise
            drive_r <= 1'b0;
            st_r <= ST_OP;
            bit_r <= 5'h00;
            wbits_r <= 5'h00;
            if (cs_rise && st_r == ST_WR && !busy) begin
               if (wbits_r == 5'd8 || wbits_r == 5'd16) begin
                  if (sr_write_ok) begin
                     // Keep latch bit, set busy bit
                     sr_r <= {wdat_r[15:10], sr_r[`SFS_SR_LATCH], 1'b1};
                     if (wbits_r == 5'd16) begin
                        cr_r <= wdat_r[7:0];
                     end
                     tmr_r <= STAT_CYC;
                     pe_kind_r <= 1'b0;
                  end
               end
            end else if (cs_rise && st_r == ST_IGN && op_r == `SFS_OP_PROG
               && bit_r == 5'd0 && wbits_r == 5'd8) begin
               pe_kind_r <= 1'b1;
            end
         end else begin
            if (rise) begin
               case (st_r)
                  ST_OP: begin
                     sh_r <= {16'h0000, op_nxt};
                     bit_r <= bit_r + 5'h01;
                     if (bit_r == 5'd7) begin
                        op_r <= op_nxt;
                        bit_r <= 5'h00;
                        case (op_nxt)
                           `SFS_OP_WR_EN: begin
                              if (!busy) begin
                                 sr_r[`SFS_SR_LATCH] <= 1'b1;
                              end
                              st_r <= ST_IGN;
                           end
                           `SFS_OP_WR_STAT: begin
                              st_r <= busy ? ST_IGN : ST_WR;
                           end
                           `SFS_OP_RDSR: begin
                              obyte_r <= sr_r;
                              st_r <= ST_DAT;
                           end
                           `SFS_OP_RDCR: begin
                              obyte_r <= cr_r;
                              st_r <= ST_DAT;
                           end
                           `SFS_OP_READ,
                           `SFS_OP_FAST,
                           `SFS_OP_PROG,
                           `SFS_OP_ERASE: begin
                              st_r <= busy ? ST_IGN : ST_ADR;
                           end
                           default: st_r <= ST_IGN;
                        endcase
                     end
                  end
                  ST_ADR: begin
                     sh_r <= adr_nxt;
                     bit_r <= bit_r + 5'h01;
                     if (bit_r == 5'd23) begin
                        addr_r <= adr_nxt[AW-1:0];
                        bit_r <= 5'h00;
                        dcnt_r <= dummy_n;
                        if (op_r == `SFS_OP_FAST) begin
                           st_r <= ST_DUM;
                        end else if (op_r == `SFS_OP_READ) begin
                           st_r <= ST_DAT;
                        end else begin
                           st_r <= ST_IGN;
                           // Latch, protection and data gate the op
                           if (write_latch && !in_prot) begin
                              if (op_r == `SFS_OP_ERASE) begin
                                 sr_r[`SFS_SR_BUSY] <= 1'b1;
                                 tmr_r <= PE_CYC;
                                 pe_kind_r <= 1'b0;
                              end else begin
                                 wbits_r <= 5'd0;
                              end
                           end else begin
                              sr_r[`SFS_SR_LATCH] <= 1'b0;
                              op_r <= 8'h00;
                           end
                        end
                     end
                  end
                  ST_DUM: begin
                     dcnt_r <= dcnt_r - 4'h1;
                     if (dcnt_r == 4'h1) begin
                        st_r <= ST_DAT;
                     end
                  end
                  ST_WR: begin
                     if (wbits_r < 5'd16) begin
                        wdat_r <= (wbits_r < 5'd8)
                           ? {wdat_r[14:8], si_q, wdat_r[7:0]}
                           : {wdat_r[15:8], wdat_r[6:0], si_q};
                     end
                     if (wbits_r != 5'd31) begin
                        wbits_r <= wbits_r + 5'h01;
                     end
                  end
                  ST_IGN: begin
                     if (op_r == `SFS_OP_PROG && wbits_r < 5'd8) begin
                        pe_dat_r <= {pe_dat_r[6:0], si_q};
                        wbits_r <= wbits_r + 5'h01;
                     end
                  end
                  ST_DAT: begin
                  end
                  default: st_r <= ST_IGN;
               endcase
            end
            if (fall && st_r == ST_DAT) begin
               drive_r <= 1'b1;
               so <= (op_r == `SFS_OP_READ || op_r == `SFS_OP_FAST)
                  ? mem_q[3'h7 - obit_r] : obyte_r[3'h7 - obit_r];
               obit_r <= obit_r + 3'h1;
               if (obit_r == 3'h7) begin
                  addr_r <= addr_r + 1'b1;
               end
            end
            if (st_r != ST_DAT) begin
               obit_r <= 3'h0;
            end
         end
         // Program start after its data byte is complete
         if (cs_rise && st_r == ST_IGN && op_r == `SFS_OP_PROG
            && wbits_r == 5'd8 && !busy) begin
            sr_r[`SFS_SR_BUSY] <= 1'b1;
            tmr_r <= PE_CYC;
         end
      end
   end
   assign so_oe_n = ~drive_r;
   sfs_mem #(
      .AW(AW)
   ) u_mem (
      .clk(clk),
      .we(pe_wr_r),
      .waddr(addr_r),
      .wdata(pe_dat_r),
      .raddr(addr_r),
      .rdata(mem_q)
   );
endmodule // sfs_top
`default_nettype wire

// [verif/sfs_props_properties.sv]
// Concurrent checks on the sfs_top ports.
// Assumes binding into every sfs_top; single clk domain.
`timescale 1ns/1ps
`default_nettype none
module sfs_props #(
   parameter STAT_CYC = 1600,
   parameter PE_CYC = 64
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link pins
   input wire logic cs_n,
   input wire logic write_protect_n_pin,
   input wire logic so_oe_n,
   // Mode and state
   input wire logic four_line_command_mode,
   input wire logic [7:0] status_reg,
   input wire logic [7:0] config_reg,
   input wire logic hardware_protect_mode,
   input wire logic software_protect_mode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [15:0] busy_cnt_r;
   always @(posedge clk or posedge rst) begin
      if (rst) busy_cnt_r <= 16'h0000;
      else if (status_reg[0]) busy_cnt_r <= busy_cnt_r + 16'h0001;
      else busy_cnt_r <= 16'h0000;
   end
   a_hw_entry: assert property ((status_reg[7] && !status_reg[6] &&
      !four_line_command_mode && !write_protect_n_pin)[*4]
      |-> hardware_protect_mode) else $error("protect mode not entered");
   a_quad_no_hw: assert property ((status_reg[6] ||
      four_line_command_mode)[*3] |-> !hardware_protect_mode)
      else $error("protect mode while quad");
   a_modes_inverse: assert property (software_protect_mode !=
      hardware_protect_mode) else $error("modes not inverse");
   a_busy_at_rise: assert property ($rose(status_reg[0]) |-> cs_n)
      else $error("busy rose inside frame");
   a_busy_length: assert property ($fell(status_reg[0]) |->
      (busy_cnt_r == STAT_CYC || busy_cnt_r == PE_CYC))
      else $error("busy length wrong");
   a_latch_cleared: assert property ($fell(status_reg[0]) |->
      !status_reg[1]) else $error("latch kept after cycle");
   a_latch_idle: assert property ($rose(status_reg[1]) |->
      !status_reg[0]) else $error("latch set while busy");
   a_status_guard: assert property (!$stable(status_reg[7:2]) |->
      $past(status_reg[1]) && !$past(hardware_protect_mode))
      else $error("status changed without permission");
   a_config_guard: assert property (!$stable(config_reg) |->
      $past(status_reg[1])) else $error("config changed without latch");
   a_out_release: assert property (cs_n[*4] |-> so_oe_n)
      else $error("output driven while deselected");
endmodule // sfs_props
bind sfs_top sfs_props #(.STAT_CYC(STAT_CYC), .PE_CYC(PE_CYC)) u_props (
   .clk(clk), .rst(rst), .cs_n(cs_n),
   .write_protect_n_pin(write_protect_n_pin), .so_oe_n(so_oe_n),
   .four_line_command_mode(four_line_command_mode),
   .status_reg(status_reg), .config_reg(config_reg),
   .hardware_protect_mode(hardware_protect_mode),
   .software_protect_mode(software_protect_mode));
`default_nettype wire

// [verif/sfs_host.sv]
// Host controller model: mode 0 frames on the serial link.
// Assumes tasks are called just after a clk edge.
`timescale 1ns/1ps
`default_nettype none
module sfs_host (
   // Clock
   input wire logic clk,
   // Link pins
   output logic cs_n,
   output logic sclk,
   output logic si,
   input wire logic so,
   input wire logic so_oe_n
);
   logic oe_seen;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
      oe_seen = 1'b0;
   end
   // MSB first, sclk still between frames, so taken just after each rise
   task automatic xfer(input logic [63:0] tx, input int n,
                       output logic [63:0] rx);
      rx = 64'h0;
      oe_seen = 1'b0;
      @(posedge clk);
      cs_n <= 1'b0;
      repeat (2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         si <= tx[63 - i];
         sclk <= 1'b0;
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         @(negedge clk);
         // Released line reads as pulled high
         rx = {rx[62:0], (so_oe_n === 1'b0) ? so : 1'b1};
         if (so_oe_n === 1'b0) oe_seen = 1'b1;
         repeat (4) @(posedge clk);
      end
      sclk <= 1'b0;
      repeat (2) @(posedge clk);
      cs_n <= 1'b1;
      si <= ~si;
      repeat (6) @(posedge clk);
      @(negedge clk);
   endtask
endmodule // sfs_host
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for sfs_top with a host model.
// Assumes sfs_defs.vh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "sfs_defs.vh"
module tb;
   logic clk, rst, wp_n, four_line, so, so_oe_n, cs_n, sclk, si, hw, sw;
   logic [7:0] status_reg, config_reg, sr, d0, d1;
   logic [63:0] rx;
   logic [31:0] seed;
   int fail_count, checks, cyc;
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   sfs_top #(.AW(10), .STAT_CYC(600), .PE_CYC(64)) dut (.clk(clk), .rst(rst),
      .cs_n(cs_n), .sclk(sclk), .si(si), .write_protect_n_pin(wp_n),
      .so(so), .so_oe_n(so_oe_n), .four_line_command_mode(four_line),
      .status_reg(status_reg), .config_reg(config_reg),
      .hardware_protect_mode(hw), .software_protect_mode(sw));
   sfs_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so),
      .so_oe_n(so_oe_n));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic int dum(input logic [1:0] sel);
      return (sel == 2'b01) ? 6 : (sel == 2'b11) ? 10 : 8;
   endfunction
   task chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask
   task op(input logic [63:0] tx, input int n);
      host.xfer(tx, n, rx);
   endtask
   task write_enable_cmd;
      op({`SFS_OP_WR_EN, 56'h0}, 8);
   endtask
   task idle;
      for (int k = 0; k < 2000 && status_reg[0] !== 1'b0; k++) @(negedge clk);
      chk(status_reg[0], 1'b0);
   endtask
   task write_status_cmd(input logic [15:0] v, input int n);
      write_enable_cmd;
      op({`SFS_OP_WR_STAT, v, 40'h0}, 8 + n);
      idle;
   endtask
   task tally_and_finish;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         tally_and_finish;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      wp_n = 1'b1;
      four_line = 1'b0;
      seed = 32'h4428238a;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(negedge clk);
      chk({status_reg, config_reg}, 16'h0007);
      seed = lfsr(seed);
      d0 = seed[7:0];
      d1 = seed[15:8];
      write_enable_cmd;
      op({`SFS_OP_PROG, 24'h3ff, d0, 24'h0}, 40);
      idle;
      write_enable_cmd;
      op({`SFS_OP_PROG, 24'h0, d1, 24'h0}, 40);
      idle;
      op({`SFS_OP_READ, 24'h3ff, 32'h0}, 48);
      chk(rx[15:0], {d0, d1});
      op({`SFS_OP_READ, 24'h3ff, 32'h0}, 36);
      chk(so_oe_n, 1'b1);
      $display("test read done");
      for (int sel = 0; sel < 4; sel++) begin
         write_status_cmd({8'h00, sel[1:0], 6'h07}, 16);
         chk(config_reg[7:6], sel[1:0]);
         op({`SFS_OP_FAST, 24'h3ff, 32'h0}, 48 + dum(sel[1:0]));
         chk(rx[15:0], {d0, d1});
      end
      $display("test fast read done");
      seed = lfsr(seed);
      sr = seed[7:0] & 8'h7c;
      op({`SFS_OP_WR_STAT, sr, 48'h0}, 16);
      repeat (40) @(negedge clk);
      chk(status_reg, 8'h00);
      write_enable_cmd;
      chk(status_reg[1], 1'b1);
      op({`SFS_OP_WR_STAT, sr, 8'hc5, 40'h0}, 24);
      op({`SFS_OP_RDSR, 56'h0}, 16);
      chk(rx[0], 1'b1);
      op({`SFS_OP_READ, 56'h0}, 48);
      chk(host.oe_seen, 1'b0);
      idle;
      chk(status_reg, {sr[7:2], 2'b00});
      chk({config_reg[7:6], config_reg[2:0]}, 5'h1d);
      op({`SFS_OP_RDCR, 56'h0}, 16);
      chk(rx[7:0], 8'hc5);
      write_status_cmd(16'h0000, 8);
      chk({config_reg[7:6], config_reg[2:0]}, 5'h1d);
      write_enable_cmd;
      op({`SFS_OP_WR_STAT, 8'h3c, 48'h0}, 20);
      repeat (40) @(negedge clk);
      chk(status_reg, 8'h02);
      op({`SFS_OP_WR_STAT, 8'h80, 48'h0}, 16);
      idle;
      chk(status_reg, 8'h80);
      @(posedge clk);
      wp_n <= 1'b0;
      repeat (6) @(negedge clk);
      chk({hw, sw}, 2'b10);
      write_status_cmd(16'h0000, 8);
      chk(status_reg, 8'h82);
      @(posedge clk);
      four_line <= 1'b1;
      repeat (4) @(negedge clk);
      chk(hw, 1'b0);
      @(posedge clk);
      four_line <= 1'b0;
      wp_n <= 1'b1;
      repeat (6) @(negedge clk);
      chk(hw, 1'b0);
      op({`SFS_OP_WR_STAT, 8'h00, 48'h0}, 16);
      idle;
      chk(status_reg, 8'h00);
      // Whole array protected: program and erase refused, latch dropped
      write_status_cmd(16'h3c00, 8);
      write_enable_cmd;
      op({`SFS_OP_PROG, 24'h3ff, ~d0, 24'h0}, 40);
      chk(status_reg, 8'h3c);
      write_enable_cmd;
      op({`SFS_OP_ERASE, 24'h000, 32'h0}, 32);
      chk(status_reg, 8'h3c);
      op({`SFS_OP_READ, 24'h3ff, 32'h0}, 40);
      chk(rx[7:0], d0);
      $display("test protection done");
      tally_and_finish;
   end
endmodule // tb
`default_nettype wire
